// >>> hdl/cod_defs.svh
// timing, length and field constants of the opcode decoder
`ifndef COD_DEFS_SVH
`define COD_DEFS_SVH

// ************************************************************
// opcode fields
// ************************************************************
`define COD_HI_MSB        7
`define COD_HI_LSB        4
`define COD_LO_MSB        3
`define COD_LO_LSB        0
`define COD_BITN_MSB      3
`define COD_BITN_LSB      1
`define COD_HI_BIT_TEST   4'h0
`define COD_HI_BIT_SETCLR 4'h1
`define COD_HI_BRANCH     4'h2
`define COD_HI_IMM        4'hA
`define COD_HI_DIR        4'hB
`define COD_HI_EXT        4'hC
`define COD_HI_IX2        4'hD
`define COD_HI_IX1        4'hE
`define COD_HI_IX         4'hF
`define COD_OPC_MUL       8'h42
`define COD_OPC_BSR       8'hAD
`define COD_LO_STORE_A    4'h7
`define COD_LO_STORE_X    4'hF
`define COD_LO_JUMP       4'hC
`define COD_LO_JSUB       4'hD
`define COD_PAGE0_HIGH    8'h00

// ************************************************************
// instruction lengths in bytes
// ************************************************************
`define COD_LEN_IMM       2'd2
`define COD_LEN_DIR       2'd2
`define COD_LEN_EXT       2'd3
`define COD_LEN_IX        2'd1
`define COD_LEN_IX1       2'd2
`define COD_LEN_IX2       2'd3
`define COD_LEN_BRANCH    2'd2
`define COD_LEN_BIT_TEST  2'd3
`define COD_LEN_BIT_SET   2'd2
`define COD_LEN_MUL       2'd1

// ************************************************************
// execution times in cycles
// ************************************************************
`define COD_CYC_IMM       4'd2
`define COD_CYC_DIR       4'd3
`define COD_CYC_EXT       4'd4
`define COD_CYC_IX        4'd3
`define COD_CYC_IX1       4'd4
`define COD_CYC_IX2       4'd5
`define COD_CYC_STORE_ADD 4'd1
`define COD_CYC_JUMP_LESS 4'd1
`define COD_CYC_JSUB_ADD  4'd2
`define COD_CYC_BRANCH    4'd3
`define COD_CYC_BSR       4'd6
`define COD_CYC_BIT       4'd5
`define COD_CYC_MUL       4'd11

`endif

// >>> hdl/cod_pkg.sv
// types shared by the opcode decoder
package cod_pkg;

	// ************************************************************
	// operations; codes 0..15 match the register/memory low nibble
	// ************************************************************
	typedef enum logic [4:0] {
		OP_SUBTRACT              = 5'h00,
		OP_COMPARE_ACCUMULATOR   = 5'h01,
		OP_SUBTRACT_WITH_BORROW  = 5'h02,
		OP_COMPARE_INDEX         = 5'h03,
		OP_AND_ACCUMULATOR       = 5'h04,
		OP_BIT_TEST              = 5'h05,
		OP_LOAD_ACCUMULATOR      = 5'h06,
		OP_STORE_ACCUMULATOR     = 5'h07,
		OP_XOR_INTO_ACCUMULATOR  = 5'h08,
		OP_ADD_WITH_CARRY        = 5'h09,
		OP_OR_INTO_ACCUMULATOR   = 5'h0A,
		OP_ADD                   = 5'h0B,
		OP_JUMP_UNCONDITIONAL    = 5'h0C,
		OP_JUMP_SUBROUTINE       = 5'h0D,
		OP_LOAD_INDEX            = 5'h0E,
		OP_STORE_INDEX           = 5'h0F,
		OP_BRANCH                = 5'h10,
		OP_BRANCH_SUBROUTINE     = 5'h11,
		OP_TEST_BIT_BRANCH_SET   = 5'h12,
		OP_TEST_BIT_BRANCH_CLEAR = 5'h13,
		OP_SET_BIT_N             = 5'h14,
		OP_CLEAR_BIT_N           = 5'h15,
		OP_UNSIGNED_MULTIPLY     = 5'h16,
		OP_NONE                  = 5'h17
	} cod_op_t;

	typedef enum logic [3:0] {
		MODE_INH = 4'h0,
		MODE_IMM = 4'h1,
		MODE_DIR = 4'h2,
		MODE_EXT = 4'h3,
		MODE_IX  = 4'h4,
		MODE_IX1 = 4'h5,
		MODE_IX2 = 4'h6,
		MODE_REL = 4'h7,
		MODE_BSC = 4'h8,
		MODE_BTB = 4'h9
	} cod_mode_t;

	typedef enum logic [0:0] {
		MUL_IDLE = 1'b0,
		MUL_BUSY = 1'b1
	} cod_mul_state_t;

	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} cod_ccr_t;

	typedef struct packed {
		logic      valid;
		logic      illegal;
		cod_op_t   op;
		cod_mode_t mode;
		logic [1:0] len;
		logic [3:0] cycles;
		logic [2:0] bit_num;
		logic      writes_acc;
		logic      writes_idx;
	} cod_dec_t;

endpackage : cod_pkg

// >>> hdl/cod_branch_cond.sv
// branch condition evaluator for the relative branch column
`timescale 1ns/100ps
`default_nettype none
`include "cod_defs.svh"

module cod_branch_cond
	import cod_pkg::*;
(
	// ************************************************************
	// condition select and inputs
	// ************************************************************
	input  wire logic [3:0] cond,
	input  wire cod_ccr_t   ccr,
	input  wire logic       irq_level,
	// ************************************************************
	// result
	// ************************************************************
	output logic            taken
);

	always_comb begin
		unique case (cond)
			4'h0: taken = 1'b1;
			4'h1: taken = 1'b0;
			4'h2: taken = ~(ccr.c | ccr.z);
			4'h3: taken = ccr.c | ccr.z;
			4'h4: taken = ~ccr.c;
			4'h5: taken = ccr.c;
			4'h6: taken = ~ccr.z;
			4'h7: taken = ccr.z;
			4'h8: taken = ~ccr.h;
			4'h9: taken = ccr.h;
			4'hA: taken = ~ccr.n;
			4'hB: taken = ccr.n;
			4'hC: taken = ~ccr.i;
			4'hD: taken = ccr.i;
			4'hE: taken = ~irq_level;
			4'hF: taken = irq_level;
		endcase
	end

endmodule : cod_branch_cond
`default_nettype wire

// >>> hdl/cod_decoder.sv
// opcode decoder with branch resolution and multiply sequencer
//
// How it works
// - add-with-carry from A9..F9, six modes
// - subtract-with-borrow A2..F2, standard arithmetic timing
// - xor-into-accumulator A8..F8, lengths per mode
// - accumulator compare sets flags, no writeback
// - index compare A3..F3, 2-5 cycles
// - bit test ANDs for flags only
// - opcode 23 taken when carry or zero
// - opcodes 24 and 25 each serve two names
// - opcodes 28/29 test half-carry
// - opcodes 2C/2D test interrupt mask
// - opcodes 2E/2F test interrupt pin level
// - all 2x branches: two bytes, 3 cycles
// - test-bit-branch-if-set: 3 bytes, 5 cycles
// - test-bit-branch-if-clear: 3 bytes, 5 cycles
// - set/clear bit: 2 bytes direct, 5 cycles
// - tested bit is copied into carry
// - bit operations only in page zero
// - multiply: 16-bit product, 11 cycles
`timescale 1ns/100ps
`default_nettype none
`include "cod_defs.svh"

module cod_decoder
	import cod_pkg::*;
(
	// ************************************************************
	// clock and reset
	// ************************************************************
	input  wire logic        clk,
	input  wire logic        rst_n,
	// ************************************************************
	// opcode fetch from program memory
	// ************************************************************
	input  wire logic        op_valid,
	input  wire logic [7:0]  opcode,
	// ************************************************************
	// condition sources
	// ************************************************************
	input  wire cod_ccr_t    ccr,
	input  wire logic        irq_level,
	input  wire logic        tested_bit,
	input  wire logic [15:0] bit_addr,
	// ************************************************************
	// multiply operands
	// ************************************************************
	input  wire logic        mul_start,
	input  wire logic [7:0]  acc_in,
	input  wire logic [7:0]  idx_in,
	// ************************************************************
	// decode results
	// ************************************************************
	output cod_dec_t         dec,
	output logic             branch_taken,
	output logic             carry_load,
	output logic             carry_value,
	output logic             bit_addr_ok,
	// ************************************************************
	// multiply results
	// ************************************************************
	output logic             mul_busy,
	output logic             mul_done,
	output logic [7:0]       mul_acc,
	output logic [7:0]       mul_idx
);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [3:0] rm_cycles(input cod_mode_t m, input logic [3:0] lo);
		logic [3:0] base;
		base = `COD_CYC_IMM;
		unique case (m)
			MODE_DIR: base = `COD_CYC_DIR;
			MODE_EXT: base = `COD_CYC_EXT;
			MODE_IX:  base = `COD_CYC_IX;
			MODE_IX1: base = `COD_CYC_IX1;
			MODE_IX2: base = `COD_CYC_IX2;
			default:  base = `COD_CYC_IMM;
		endcase
		// stores write back one cycle later; jumps skip the operand read
		if (lo == `COD_LO_STORE_A || lo == `COD_LO_STORE_X)
			return base + `COD_CYC_STORE_ADD;
		else if (lo == `COD_LO_JUMP)
			return base - `COD_CYC_JUMP_LESS;
		else if (lo == `COD_LO_JSUB)
			return base + `COD_CYC_JSUB_ADD;
		return base;
	endfunction : rm_cycles

	function automatic logic acc_written(input cod_op_t o);
		unique case (o)
			OP_SUBTRACT, OP_SUBTRACT_WITH_BORROW, OP_AND_ACCUMULATOR,
			OP_LOAD_ACCUMULATOR, OP_XOR_INTO_ACCUMULATOR, OP_ADD_WITH_CARRY,
			OP_OR_INTO_ACCUMULATOR, OP_ADD, OP_UNSIGNED_MULTIPLY: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : acc_written

	// ************************************************************
	// decode
	// ************************************************************
	logic [3:0] hi;
	logic [3:0] lo;
	logic       cond_taken;
	cod_dec_t   next_dec;
	logic       next_branch_taken;
	logic       next_carry_load;
	logic       next_carry_value;
	logic       next_bit_addr_ok;

	assign hi = opcode[`COD_HI_MSB:`COD_HI_LSB];
	assign lo = opcode[`COD_LO_MSB:`COD_LO_LSB];

	cod_branch_cond u_cond (
		.cond      (lo),
		.ccr       (ccr),
		.irq_level (irq_level),
		.taken     (cond_taken)
	);

	always_comb begin
		next_dec            = '0;
		next_dec.op         = OP_NONE;
		next_dec.mode       = MODE_INH;
		next_dec.valid      = op_valid;
		next_branch_taken   = 1'b0;
		next_carry_load     = 1'b0;
		next_carry_value    = 1'b0;
		next_bit_addr_ok    = 1'b0;
		next_dec.bit_num    = opcode[`COD_BITN_MSB:`COD_BITN_LSB];
		if (op_valid) begin
			unique case (hi)
				`COD_HI_BIT_TEST: begin
					next_dec.op      = opcode[0] ? OP_TEST_BIT_BRANCH_CLEAR :
					                               OP_TEST_BIT_BRANCH_SET;
					next_dec.mode    = MODE_BTB;
					next_dec.len     = `COD_LEN_BIT_TEST;
					next_dec.cycles  = `COD_CYC_BIT;
					next_branch_taken = tested_bit ^ opcode[0];
					next_carry_load  = 1'b1;
					next_carry_value = tested_bit;
					next_bit_addr_ok = (bit_addr[15:8] == `COD_PAGE0_HIGH);
				end
				`COD_HI_BIT_SETCLR: begin
					next_dec.op      = opcode[0] ? OP_CLEAR_BIT_N : OP_SET_BIT_N;
					next_dec.mode    = MODE_BSC;
					next_dec.len     = `COD_LEN_BIT_SET;
					next_dec.cycles  = `COD_CYC_BIT;
					next_bit_addr_ok = (bit_addr[15:8] == `COD_PAGE0_HIGH);
				end
				`COD_HI_BRANCH: begin
					next_dec.op       = OP_BRANCH;
					next_dec.mode     = MODE_REL;
					next_dec.len      = `COD_LEN_BRANCH;
					next_dec.cycles   = `COD_CYC_BRANCH;
					next_branch_taken = cond_taken;
				end
				`COD_HI_IMM, `COD_HI_DIR, `COD_HI_EXT,
				`COD_HI_IX2, `COD_HI_IX1, `COD_HI_IX: begin
					unique case (hi)
						`COD_HI_IMM: begin
							next_dec.mode = MODE_IMM;
							next_dec.len  = `COD_LEN_IMM;
						end
						`COD_HI_DIR: begin
							next_dec.mode = MODE_DIR;
							next_dec.len  = `COD_LEN_DIR;
						end
						`COD_HI_EXT: begin
							next_dec.mode = MODE_EXT;
							next_dec.len  = `COD_LEN_EXT;
						end
						`COD_HI_IX2: begin
							next_dec.mode = MODE_IX2;
							next_dec.len  = `COD_LEN_IX2;
						end
						`COD_HI_IX1: begin
							next_dec.mode = MODE_IX1;
							next_dec.len  = `COD_LEN_IX1;
						end
						default: begin
							next_dec.mode = MODE_IX;
							next_dec.len  = `COD_LEN_IX;
						end
					endcase
					next_dec.op     = cod_op_t'({1'b0, lo});
					next_dec.cycles = rm_cycles(next_dec.mode, lo);
					if (opcode == `COD_OPC_BSR) begin
						next_dec.op       = OP_BRANCH_SUBROUTINE;
						next_dec.mode     = MODE_REL;
						next_dec.len      = `COD_LEN_BRANCH;
						next_dec.cycles   = `COD_CYC_BSR;
						next_branch_taken = 1'b1;
					end else if (hi == `COD_HI_IMM && (lo == `COD_LO_STORE_A ||
					             lo == `COD_LO_STORE_X || lo == `COD_LO_JUMP)) begin
						next_dec.op      = OP_NONE;
						next_dec.illegal = 1'b1;
						next_dec.len     = '0;
						next_dec.cycles  = '0;
					end
				end
				default: begin
					// read/modify/write and control groups are flagged illegal, except the multiply opcode
					if (opcode == `COD_OPC_MUL) begin
						next_dec.op     = OP_UNSIGNED_MULTIPLY;
						next_dec.len    = `COD_LEN_MUL;
						next_dec.cycles = `COD_CYC_MUL;
					end else begin
						next_dec.illegal = 1'b1;
					end
				end
			endcase
			next_dec.writes_acc = acc_written(next_dec.op);
			next_dec.writes_idx = (next_dec.op == OP_LOAD_INDEX) ||
			                      (next_dec.op == OP_UNSIGNED_MULTIPLY);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec          <= '0;
			branch_taken <= 1'b0;
			carry_load   <= 1'b0;
			carry_value  <= 1'b0;
			bit_addr_ok  <= 1'b0;
		end else begin
			dec          <= next_dec;
			branch_taken <= next_branch_taken;
			carry_load   <= next_carry_load;
			carry_value  <= next_carry_value;
			bit_addr_ok  <= next_bit_addr_ok;
		end
	end

	// ************************************************************
	// multiply sequencer
	// ************************************************************
	cod_mul_state_t mul_state;
	cod_mul_state_t next_mul_state;
	logic [3:0]     mul_cnt;
	logic [3:0]     next_mul_cnt;
	logic [15:0]    product;
	logic [7:0]     next_mul_acc;
	logic [7:0]     next_mul_idx;

	assign product  = {8'h00, idx_in} * {8'h00, acc_in};
	assign mul_busy = (mul_state == MUL_BUSY);
	assign mul_done = mul_busy && (mul_cnt == `COD_CYC_MUL);

	always_comb begin
		next_mul_state = mul_state;
		next_mul_cnt   = mul_cnt;
		next_mul_acc   = mul_acc;
		next_mul_idx   = mul_idx;
		unique case (mul_state)
			MUL_IDLE: begin
				if (mul_start) begin
					// operands are caught at start, so they may change while busy
					next_mul_state = MUL_BUSY;
					next_mul_cnt   = 4'h1;
					next_mul_idx   = product[15:8];
					next_mul_acc   = product[7:0];
				end
			end
			MUL_BUSY: begin
				if (mul_cnt == `COD_CYC_MUL)
					next_mul_state = MUL_IDLE;
				else
					next_mul_cnt = mul_cnt + 4'h1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mul_state <= MUL_IDLE;
			mul_cnt   <= 4'h0;
			mul_acc   <= 8'h00;
			mul_idx   <= 8'h00;
		end else begin
			mul_state <= next_mul_state;
			mul_cnt   <= next_mul_cnt;
			mul_acc   <= next_mul_acc;
			mul_idx   <= next_mul_idx;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_adc_imm_time: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode == 8'hA9 |=> dec.op == OP_ADD_WITH_CARRY && dec.cycles == 4'd2
		&& dec.len == 2'd2)
		else $error("adc immediate decode wrong");
	a_adc_ix2_time: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode == 8'hD9 |=> dec.mode == MODE_IX2 && dec.cycles == 4'd5)
		else $error("adc 16-bit indexed timing wrong");
	a_sbc_dir_time: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode == 8'hB2 |=> dec.op == OP_SUBTRACT_WITH_BORROW
		&& dec.cycles == 4'd3 && dec.writes_acc)
		else $error("sbc direct decode wrong");
	a_xor_ix_len: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode == 8'hF8 |=> dec.op == OP_XOR_INTO_ACCUMULATOR && dec.len == 2'd1)
		else $error("xor indexed length wrong");
	a_compare_no_wb: assert property (
		@(posedge clk) disable iff (!rst_n)
		dec.valid && (dec.op == OP_COMPARE_ACCUMULATOR || dec.op == OP_BIT_TEST)
		|-> !dec.writes_acc && !dec.writes_idx)
		else $error("compare or bit test writes a register");
	a_cpx_ix1_time: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode == 8'hE3 |=> dec.op == OP_COMPARE_INDEX && dec.cycles == 4'd4)
		else $error("index compare 8-bit offset timing wrong");
	a_branch_shape: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode[7:4] == 4'h2 |=> dec.len == 2'd2 && dec.cycles == 4'd3)
		else $error("relative branch size or time wrong");
	a_lower_same_cond: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode == 8'h23 |=> branch_taken == ($past(ccr.c) | $past(ccr.z)))
		else $error("lower-or-same condition wrong");
	a_irq_low_cond: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode == 8'h2E |=> branch_taken == !$past(irq_level))
		else $error("irq line low branch wrong");
	a_tested_carry: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && opcode[7:4] == 4'h0 |=> carry_load && carry_value == $past(tested_bit)
		&& dec.cycles == 4'd5 && dec.len == 2'd3)
		else $error("tested bit not copied to carry");
	a_bit_page0: assert property (
		@(posedge clk) disable iff (!rst_n)
		bit_addr_ok |-> (dec.mode == MODE_BSC || dec.mode == MODE_BTB)
		&& $past(bit_addr[15:8]) == 8'h00)
		else $error("bit operation outside page zero accepted");
	a_no_imm_store: assert property (
		@(posedge clk) disable iff (!rst_n)
		op_valid && (opcode == 8'hA7 || opcode == 8'hAC) |=> dec.illegal && dec.op == OP_NONE)
		else $error("immediate store or jump decoded");
	a_mul_eleven: assert property (
		@(posedge clk) disable iff (!rst_n)
		mul_start && !mul_busy |=> (mul_busy && !mul_done)[*5] ##1
		(mul_busy && !mul_done)[*5] ##1 mul_done)
		else $error("multiply not done in 11 cycles");

endmodule : cod_decoder
`default_nettype wire

// >>> testbench/cod_prog_mem.sv
// program memory model that hands opcode bytes to the decoder
`timescale 1ns/100ps
`default_nettype none

module cod_prog_mem (
	// ************************************************************
	// clock and fetch request
	// ************************************************************
	input  wire logic       clk,
	input  wire logic       want,
	input  wire logic [7:0] byte_in,
	// ************************************************************
	// bytes towards the decoder
	// ************************************************************
	output logic            op_valid,
	output logic [7:0]      opcode
);
	logic [7:0] filler = 8'h00;

	// idle bus shows a moving pattern so a stale opcode is never mistaken for a real one
	always_ff @(posedge clk) filler <= filler + 8'h3B;
	assign op_valid = want;
	assign opcode   = want ? byte_in : filler;
endmodule : cod_prog_mem

`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the opcode decoder
`timescale 1ns/100ps
`default_nettype none

module testbench
	import cod_pkg::*;
;
	logic        clk, rst_n, want, op_valid, tested_bit, irq_level, mul_start;
	logic [7:0]  byte_in, opcode, acc_in, idx_in, mul_acc, mul_idx;
	logic [15:0] bit_addr;
	cod_ccr_t    ccr;
	cod_dec_t    dec;
	logic        branch_taken, carry_load, carry_value, bit_addr_ok, mul_busy, mul_done;
	logic [31:0] seed = 32'h4E3F;
	int          num_errors = 0;
	int          compares   = 0;
	int          mdt[6] = '{1, 2, 3, 6, 5, 4};
	int          lnt[6] = '{2, 2, 3, 3, 2, 1};
	int          cyt[6] = '{2, 3, 4, 5, 4, 3};

	cod_prog_mem u_cod_prog_mem (.clk(clk), .want(want), .byte_in(byte_in),
		.op_valid(op_valid), .opcode(opcode));
	cod_decoder u_cod_decoder (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode),
		.ccr(ccr), .irq_level(irq_level), .tested_bit(tested_bit), .bit_addr(bit_addr),
		.mul_start(mul_start), .acc_in(acc_in), .idx_in(idx_in), .dec(dec),
		.branch_taken(branch_taken), .carry_load(carry_load), .carry_value(carry_value),
		.bit_addr_ok(bit_addr_ok), .mul_busy(mul_busy), .mul_done(mul_done),
		.mul_acc(mul_acc), .mul_idx(mul_idx));

	// ************************************************************
	// clock, checking and verdict
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// branch condition per low nibble of the 2x column
	function automatic int brc(input int lo, input cod_ccr_t f, input logic irq);
		case (lo)
			0: return 1;
			1: return 0;
			2: return !(f.c | f.z);
			3: return f.c | f.z;
			4: return !f.c;
			5: return f.c;
			6: return !f.z;
			7: return f.z;
			8: return !f.h;
			9: return f.h;
			10: return !f.n;
			11: return f.n;
			12: return !f.i;
			13: return f.i;
			14: return !irq;
			default: return irq;
		endcase
	endfunction : brc

	// ************************************************************
	// one decode, checked against the reference tables
	// ************************************************************
	task automatic dec_one(input logic [7:0] o, input logic v);
		logic [31:0] r;
		int hi, lo, op, md, ln, cy, tk, ill, wa, wi;
		r = xs();
		want = v;
		byte_in = o;
		ccr = cod_ccr_t'(r[4:0]);
		irq_level = r[5];
		tested_bit = r[6];
		bit_addr = {(r[7] ? 8'h00 : r[15:8]), r[23:16]};
		@(posedge clk);
		#1;
		hi = o[7:4]; lo = o[3:0]; ill = 0; wa = 0; wi = 0; tk = 0; md = 0;
		if (hi == 0) begin
			op = lo[0] ? 19 : 18; md = 9; ln = 3; cy = 5; tk = tested_bit ^ o[0];
		end else if (hi == 1) begin
			op = lo[0] ? 21 : 20; md = 8; ln = 2; cy = 5;
		end else if (hi == 2) begin
			op = 16; md = 7; ln = 2; cy = 3; tk = brc(lo, ccr, irq_level);
		end else if (o == 8'h42) begin
			op = 22; ln = 1; cy = 11; wa = 1; wi = 1;
		end else if (o == 8'hAD) begin
			op = 17; md = 7; ln = 2; cy = 6; tk = 1;
		end else if (hi >= 10 && !(hi == 10 && (lo == 7 || lo == 12 || lo == 15))) begin
			op = lo; md = mdt[hi-10]; ln = lnt[hi-10]; cy = cyt[hi-10];
			cy = cy + ((lo == 7 || lo == 15) ? 1 : 0) - ((lo == 12) ? 1 : 0) + ((lo == 13) ? 2 : 0);
			wa = (lo inside {0, 2, 4, 6, 8, 9, 10, 11}) ? 1 : 0;
			wi = (lo == 14) ? 1 : 0;
		end else begin
			ill = 1; op = 23; ln = 0; cy = 0;
		end
		check("valid", 16'(dec.valid), 16'(v));
		if (v) begin
			check("illegal", 16'(dec.illegal), 16'(ill));
			check("op", 16'(dec.op), 16'(op));
			check("len", 16'(dec.len), 16'(ln));
			check("cycles", 16'(dec.cycles), 16'(cy));
			check("carry_load", 16'(carry_load), 16'(hi == 0));
			check("bit_addr_ok", 16'(bit_addr_ok), 16'(hi < 2 && bit_addr[15:8] == 8'h00));
			if (!ill) begin
				check("mode", 16'(dec.mode), 16'(md));
				check("writes_acc", 16'(dec.writes_acc), 16'(wa));
				check("writes_idx", 16'(dec.writes_idx), 16'(wi));
			end
			if (hi < 2)
				check("bit_num", 16'(dec.bit_num), 16'(o[3:1]));
			if (hi == 0 || hi == 2 || o == 8'hAD)
				check("branch_taken", 16'(branch_taken), 16'(tk));
			if (hi == 0)
				check("carry_value", 16'(carry_value), 16'(tested_bit));
		end
	endtask : dec_one

	// ************************************************************
	// multiply with a refused start while busy
	// ************************************************************
	task automatic mul_run(input logic [7:0] a, input logic [7:0] x);
		logic [15:0] p;
		p = 16'(x) * 16'(a);
		mul_start = 1'b1;
		acc_in = a;
		idx_in = x;
		@(posedge clk);
		#1;
		mul_start = 1'b0;
		for (int c = 1; c <= 12; c++) begin
			check("mul_busy", 16'(mul_busy), 16'(c <= 11));
			check("mul_done", 16'(mul_done), 16'(c == 11));
			check("mul_prod", {mul_idx, mul_acc}, p);
			// starts in mid-run and in the done cycle must both be ignored
			mul_start = (c == 5 || c == 11);
			acc_in = ~a;
			idx_in = x + 8'h01;
			@(posedge clk);
			#1;
			mul_start = 1'b0;
		end
		$display("test multiply %h x %h done", a, x);
	endtask : mul_run

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		rst_n = 1'b0; want = 1'b0; byte_in = 8'h00; ccr = '0; irq_level = 1'b0;
		tested_bit = 1'b0; bit_addr = 16'h0000; mul_start = 1'b0;
		acc_in = 8'h00; idx_in = 8'h00;
		repeat (3) @(posedge clk);
		#1;
		check("reset_dec", 16'(dec.valid), 16'h0000);
		check("reset_busy", 16'(mul_busy), 16'h0000);
		rst_n = 1'b1;
		for (int i = 0; i < 256; i++) dec_one(8'(i), 1'b1);
		$display("test full opcode sweep done");
		for (int i = 0; i < 400; i++) dec_one(8'(xs()), 3'(xs()) != 3'h0);
		$display("test random back to back done");
		want = 1'b0;
		mul_run(8'hFF, 8'hFF);
		mul_run(8'(xs()), 8'(xs()));
		mul_run(8'h00, 8'h9C);
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
